// >>> srcp_params.svh
// Purpose: shared constants of the serial register control port
// Assumes: included by bare name
// Notes: offsets are register addresses on the link
`ifndef SRCP_PARAMS_SVH
`define SRCP_PARAMS_SVH
`define SRCP_ADDR_CFG_A 14'h0000
`define SRCP_ADDR_CFG_B 14'h0001
`define SRCP_ADDR_TRIG 14'h000F
`define SRCP_ADDR_FIRST 14'h0000
`define SRCP_ADDR_LAST 14'h3A3B
`define SRCP_NUM_REGS 16
`define SRCP_BUF_LO 2
`define SRCP_BUF_HI 14
`define SRCP_BIT_LSB_FIRST 6
`define SRCP_BIT_ASCEND 5
`define SRCP_BIT_FOUR_WIRE 4
`define SRCP_BIT_READ_BUF 5
`define SRCP_BIT_UPDATE 0
`define SRCP_CFG_A_RST 8'h00
`define SRCP_CFG_B_RST 8'h00
`define SRCP_INSTR_BITS 16
`define SRCP_STRAP_SPI 1'b1
`define SRCP_CLK_SYS_NS 10
`define SRCP_SCLK_MIN_PERIOD_NS 20
`define SRCP_SCLK_HALF_MIN ((`SRCP_SCLK_MIN_PERIOD_NS + 2 * `SRCP_CLK_SYS_NS - 1) / (2 * `SRCP_CLK_SYS_NS))
`define SRCP_SCLK_HALF 4
`endif

// >>> srcp_pkg.sv
// Purpose: types and helpers of the serial register control port
// Assumes: srcp_params.svh for numbers
// Notes: none
`include "srcp_params.svh"
package srcp_pkg;
	typedef logic [13:0] srcp_addr_t;
	typedef logic [7:0] srcp_byte_t;
	typedef logic [`SRCP_NUM_REGS-1:0][7:0] srcp_regs_t;
	typedef enum logic [3:0] {
		HS_IDLE = 4'b0001,
		HS_SETUP = 4'b0010,
		HS_SHIFT = 4'b0100,
		HS_HOLD = 4'b1000
	} srcp_hstate_t;

	function automatic logic srcp_pick8(input srcp_byte_t b,
		input logic [2:0] i, input logic lsb);
		srcp_pick8 = lsb ? b[i] : b[3'd7 - i];
	endfunction

	function automatic srcp_byte_t srcp_shin8(input srcp_byte_t b,
		input logic d, input logic lsb);
		srcp_shin8 = lsb ? {d, b[7:1]} : {b[6:0], d};
	endfunction
endpackage

// >>> srcp_if.sv
// Purpose: link wires between host and device ends
// Assumes: each two-way pin is value plus enable per end
// Notes: undriven lines read high, as the chip select pull-up does
interface srcp_if;
	logic shift_clk;
	logic chip_select_n;
	logic sdio_host_o;
	logic sdio_host_oe;
	logic sdio_dev_o;
	logic sdio_dev_oe;
	logic serial_data_out;
	logic serial_data_out_oe;
	logic sdio_level;
	logic sdo_level;
	assign sdio_level = sdio_dev_oe ? sdio_dev_o :
		(sdio_host_oe ? sdio_host_o : 1'b1);
	assign sdo_level = serial_data_out_oe ? serial_data_out : 1'b1;
	modport device (
		input shift_clk,
		input chip_select_n,
		input sdio_level,
		output sdio_dev_o,
		output sdio_dev_oe,
		output serial_data_out,
		output serial_data_out_oe
	);
	modport host (
		output shift_clk,
		output chip_select_n,
		output sdio_host_o,
		output sdio_host_oe,
		input sdio_level,
		input sdo_level
	);
endinterface

// >>> srcp_sync.sv
// Purpose: two flip-flop level synchroniser
// Assumes: synchronous active-low reset
// Notes: only q may be read
module srcp_sync (
	input wire logic clk,
	input wire logic rstn,
	input wire logic d,
	output logic q
);
	logic meta_reg;
	always_ff @(posedge clk)
	begin
		if (!rstn)
		begin
			meta_reg <= 1'b0;
			q <= 1'b0;
		end
		else
		begin
			meta_reg <= d;
			q <= meta_reg;
		end
	end
endmodule

// >>> srcp_host.sv
// Purpose: link master; makes shift clock, runs one frame per command
// Assumes: cmd_lsb and cmd_four_wire match the device's current setup
// Notes: stalls with shift clock low while write data is missing
`include "srcp_params.svh"
module srcp_host (
	srcp_if.host link,
	input wire logic clk_sys,
	input wire logic rstn,
	input wire logic cmd_valid,
	output logic cmd_ready,
	input wire logic cmd_read,
	input wire logic [14:0] cmd_addr,
	input wire logic [7:0] cmd_len,
	input wire logic cmd_lsb,
	input wire logic cmd_four_wire,
	input wire logic wr_valid,
	output logic wr_ready,
	input wire logic [7:0] wr_data,
	output logic rd_valid,
	output logic [7:0] rd_data,
	output logic busy
);
	import srcp_pkg::*;
	localparam logic [2:0] PH_HALF = 3'(`SRCP_SCLK_HALF);
	localparam logic [2:0] PH_LAST = 3'(2 * `SRCP_SCLK_HALF - 1);
	srcp_hstate_t st_reg;
	logic [2:0] ph_reg;
	logic [3:0] bit_reg;
	logic instr_reg, rd_reg, lsb_reg, fw_reg;
	logic [7:0] left_reg;
	logic [15:0] word_reg;
	srcp_byte_t tx_reg, rx_reg;
	logic sclk_reg, cs_n_reg, mosi_reg, oe_reg;
	logic sdio_s, sdo_s, din, load;
	srcp_sync u_sdio (.clk(clk_sys), .rstn(rstn), .d(link.sdio_level),
		.q(sdio_s));
	srcp_sync u_sdo (.clk(clk_sys), .rstn(rstn), .d(link.sdo_level),
		.q(sdo_s));
	assign din = fw_reg ? sdo_s : sdio_s;
	assign cmd_ready = (st_reg == HS_IDLE);
	assign busy = (st_reg != HS_IDLE);
	assign load = (st_reg == HS_SHIFT) && (ph_reg == 3'd0) && !instr_reg
		&& (bit_reg == 4'd0) && !rd_reg;
	assign wr_ready = load;
	assign link.shift_clk = sclk_reg;
	assign link.chip_select_n = cs_n_reg;
	assign link.sdio_host_o = mosi_reg;
	assign link.sdio_host_oe = oe_reg;

	always_ff @(posedge clk_sys)
	begin
		if (!rstn)
		begin
			st_reg <= HS_IDLE;
			ph_reg <= 3'd0;
			bit_reg <= 4'd0;
			instr_reg <= 1'b1;
			{rd_reg, lsb_reg, fw_reg} <= 3'b000;
			left_reg <= 8'h00;
			word_reg <= 16'h0000;
			tx_reg <= 8'h00;
			rx_reg <= 8'h00;
			{sclk_reg, cs_n_reg, mosi_reg, oe_reg} <= 4'b0100;
			rd_valid <= 1'b0;
			rd_data <= 8'h00;
		end
		else
		begin
			rd_valid <= 1'b0;
			unique case (st_reg)
				HS_IDLE:
				begin
					if (cmd_valid)
					begin
						// the top address bit always goes out as zero
						word_reg <= {cmd_read, 1'b0, cmd_addr[13:0]};
						{rd_reg, lsb_reg, fw_reg} <= {cmd_read, cmd_lsb, cmd_four_wire};
						left_reg <= (cmd_len == 8'h00) ? 8'h01 : cmd_len;
						{instr_reg, bit_reg, ph_reg} <= {1'b1, 4'd0, 3'd0};
						cs_n_reg <= 1'b0;
						st_reg <= HS_SETUP;
					end
				end
				HS_SETUP:
				begin
					ph_reg <= ph_reg + 3'd1;
					if (ph_reg == PH_HALF - 3'd1)
					begin
						ph_reg <= 3'd0;
						st_reg <= HS_SHIFT;
					end
				end
				HS_SHIFT:
				begin
					if (!(load && !wr_valid))
						ph_reg <= (ph_reg == PH_LAST) ? 3'd0 : ph_reg + 3'd1;
					sclk_reg <= (ph_reg >= PH_HALF - 3'd1) && (ph_reg != PH_LAST);
					if (ph_reg == 3'd0)
					begin
						oe_reg <= instr_reg || !rd_reg || fw_reg;
						if (instr_reg)
							mosi_reg <= lsb_reg ? word_reg[bit_reg]
								: word_reg[4'd15 - bit_reg];
						else if (load)
						begin
							tx_reg <= wr_data;
							mosi_reg <= srcp_pick8(wr_data, 3'd0, lsb_reg);
						end
						else
							mosi_reg <= srcp_pick8(tx_reg, bit_reg[2:0], lsb_reg);
					end
					// sample just as the shift clock rises
					if (ph_reg == PH_HALF - 3'd1 && !instr_reg && rd_reg)
					begin
						rx_reg <= srcp_shin8(rx_reg, din, lsb_reg);
						if (bit_reg == 4'd7)
						begin
							rd_data <= srcp_shin8(rx_reg, din, lsb_reg);
							rd_valid <= 1'b1;
						end
					end
					if (ph_reg == PH_LAST)
					begin
						bit_reg <= bit_reg + 4'd1;
						if (instr_reg && bit_reg == 4'd15)
						begin
							instr_reg <= 1'b0;
							bit_reg <= 4'd0;
							// let go on the same fall the device starts driving
							oe_reg <= !rd_reg || fw_reg;
						end
						else if (!instr_reg && bit_reg == 4'd7)
						begin
							bit_reg <= 4'd0;
							left_reg <= left_reg - 8'd1;
							if (left_reg == 8'd1)
							begin
								st_reg <= HS_HOLD;
								oe_reg <= 1'b0;
							end
						end
					end
				end
				HS_HOLD:
				begin
					ph_reg <= ph_reg + 3'd1;
					if (ph_reg == PH_HALF - 3'd1)
					begin
						ph_reg <= 3'd0;
						cs_n_reg <= 1'b1;
						st_reg <= HS_IDLE;
					end
				end
			endcase
		end
	end
endmodule

// >>> srcp_device.sv
// Purpose: link slave end giving a host access to a small register map
// Assumes: link logic runs on the host's shift clock, framed by select
// Notes: update copies buffers in the system domain; host keeps buffers
//   still for a few system cycles after triggering an update
`include "srcp_params.svh"
module srcp_device (
	srcp_if.device link,
	input wire logic clk_sys,
	input wire logic rstn,
	input wire logic protocol_select_strap,
	input wire logic io_update_pin,
	output logic spi_enabled,
	output srcp_pkg::srcp_regs_t active_regs
);
	import srcp_pkg::*;
	localparam int NREG = `SRCP_NUM_REGS;
	localparam srcp_addr_t ADDR_TRIG = `SRCP_ADDR_TRIG;
	localparam srcp_addr_t ADDR_LAST = `SRCP_ADDR_LAST;
	localparam srcp_addr_t ADDR_FIRST = `SRCP_ADDR_FIRST;

	function automatic srcp_addr_t step_addr(input srcp_addr_t a,
		input logic up);
		if (up)
			step_addr = (a == ADDR_LAST) ? a : a + 14'd1;
		else
			step_addr = (a == ADDR_FIRST) ? a : a - 14'd1;
	endfunction

	// system domain: strap capture, update requests, active copy
	logic strap_s, tgl_s, tgl_d_reg, pin_s, pin_d_reg, upd_evt;
	logic [1:0] boot_cnt_reg;
	logic spi_sel_reg;
	logic upd_tgl_reg;
	srcp_byte_t buf_mem [NREG];
	srcp_byte_t act_mem [NREG];

	srcp_sync u_strap (.clk(clk_sys), .rstn(rstn),
		.d(protocol_select_strap), .q(strap_s));
	srcp_sync u_tgl (.clk(clk_sys), .rstn(rstn), .d(upd_tgl_reg),
		.q(tgl_s));
	srcp_sync u_pin (.clk(clk_sys), .rstn(rstn), .d(io_update_pin),
		.q(pin_s));

	always_ff @(posedge clk_sys)
	begin
		if (!rstn)
		begin
			boot_cnt_reg <= 2'd0;
			spi_sel_reg <= 1'b0;
		end
		else if (boot_cnt_reg != 2'd3)
		begin
			boot_cnt_reg <= boot_cnt_reg + 2'd1;
			// caught once after release; held until the next reset
			if (boot_cnt_reg == 2'd2)
				spi_sel_reg <= (strap_s == `SRCP_STRAP_SPI);
		end
	end
	assign spi_enabled = spi_sel_reg;

	always_ff @(posedge clk_sys)
	begin
		if (!rstn)
		begin
			tgl_d_reg <= 1'b0;
			pin_d_reg <= 1'b0;
		end
		else
		begin
			tgl_d_reg <= tgl_s;
			pin_d_reg <= pin_s;
		end
	end
	assign upd_evt = (tgl_s != tgl_d_reg) || (pin_s && !pin_d_reg);

	genvar gi;
	generate
		for (gi = 0; gi < NREG; gi++)
		begin : g_act
			if (gi >= `SRCP_BUF_LO && gi <= `SRCP_BUF_HI)
			begin : g_buffered
				always_ff @(posedge clk_sys)
				begin
					if (!rstn)
						act_mem[gi] <= 8'h00;
					else if (upd_evt)
						act_mem[gi] <= buf_mem[gi];
				end
			end
			else
			begin : g_direct
				always_comb act_mem[gi] = buf_mem[gi];
			end
			assign active_regs[gi] = act_mem[gi];
		end
	endgenerate

	// link domain: frame logic reset by select high
	logic cs_n;
	logic din;
	logic [4:0] icnt_reg;
	logic [2:0] bcnt_reg;
	logic [15:0] instr_reg;
	logic [15:0] instr_next;
	srcp_byte_t rx_reg, rx_next, tx_reg, rd_data;
	srcp_addr_t addr_reg, rd_addr;
	logic rd_reg, lsb_frame_reg, lsb_eff, in_payload, byte_done, wr_en;
	logic out_reg, drv_reg;
	logic cfg_lsb, cfg_up, cfg_fw, cfg_rdbuf;

	assign cs_n = link.chip_select_n;
	assign din = link.sdio_level;
	assign cfg_lsb = buf_mem[0][`SRCP_BIT_LSB_FIRST];
	assign cfg_up = buf_mem[0][`SRCP_BIT_ASCEND];
	assign cfg_fw = buf_mem[0][`SRCP_BIT_FOUR_WIRE];
	assign cfg_rdbuf = buf_mem[1][`SRCP_BIT_READ_BUF];
	// order is fixed for the whole frame once its first bit is in
	assign lsb_eff = (icnt_reg == 5'd0) ? cfg_lsb : lsb_frame_reg;
	assign instr_next = lsb_eff ? {din, instr_reg[15:1]}
		: {instr_reg[14:0], din};
	assign rx_next = srcp_shin8(rx_reg, din, lsb_eff);
	assign in_payload = (icnt_reg == 5'(`SRCP_INSTR_BITS));
	assign byte_done = in_payload && (bcnt_reg == 3'd7);
	assign wr_en = spi_sel_reg && !cs_n && byte_done && !rd_reg;
	assign rd_addr = in_payload ? addr_reg : instr_next[13:0];

	always_comb
	begin
		rd_data = 8'h00;
		if (rd_addr < 14'(NREG))
		begin
			if (rd_addr == ADDR_TRIG)
				rd_data = 8'h00;
			else if (cfg_rdbuf)
				rd_data = buf_mem[rd_addr[3:0]];
			else
				rd_data = act_mem[rd_addr[3:0]];
		end
	end

	always_ff @(posedge link.shift_clk or posedge cs_n)
	begin
		if (cs_n)
		begin
			// an unfinished byte is simply lost here
			icnt_reg <= 5'd0;
			bcnt_reg <= 3'd0;
			instr_reg <= 16'h0000;
			rx_reg <= 8'h00;
			tx_reg <= 8'h00;
			addr_reg <= 14'h0000;
			rd_reg <= 1'b0;
			lsb_frame_reg <= 1'b0;
		end
		else if (spi_sel_reg)
		begin
			if (icnt_reg == 5'd0)
				lsb_frame_reg <= cfg_lsb;
			if (!in_payload)
			begin
				instr_reg <= instr_next;
				icnt_reg <= icnt_reg + 5'd1;
				if (icnt_reg == 5'(`SRCP_INSTR_BITS - 1))
				begin
					rd_reg <= instr_next[15];
					if (instr_next[15])
					begin
						tx_reg <= rd_data;
						addr_reg <= step_addr(rd_addr, cfg_up);
					end
					else
						// bit 14 is never looked at
						addr_reg <= instr_next[13:0];
				end
			end
			else
			begin
				rx_reg <= rx_next;
				bcnt_reg <= bcnt_reg + 3'd1;
				if (byte_done)
				begin
					if (rd_reg)
						tx_reg <= rd_data;
					addr_reg <= step_addr(addr_reg, cfg_up);
				end
			end
		end
	end

	// register writes land at the end of each payload byte
	always_ff @(posedge link.shift_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			for (int i = 0; i < NREG; i++)
				buf_mem[i] <= 8'h00;
			buf_mem[0] <= `SRCP_CFG_A_RST;
			buf_mem[1] <= `SRCP_CFG_B_RST;
			upd_tgl_reg <= 1'b0;
		end
		else if (wr_en && addr_reg < 14'(NREG))
		begin
			// the trigger bit is never stored, so it reads back zero
			if (addr_reg == ADDR_TRIG)
				upd_tgl_reg <= upd_tgl_reg ^ rx_next[`SRCP_BIT_UPDATE];
			else
				buf_mem[addr_reg[3:0]] <= rx_next;
		end
	end

	always_ff @(negedge link.shift_clk or posedge cs_n)
	begin
		if (cs_n)
		begin
			out_reg <= 1'b0;
			drv_reg <= 1'b0;
		end
		else
		begin
			out_reg <= srcp_pick8(tx_reg, bcnt_reg, lsb_frame_reg);
			drv_reg <= spi_sel_reg && rd_reg && in_payload;
		end
	end

	assign link.sdio_dev_o = out_reg;
	assign link.serial_data_out = out_reg;
	assign link.sdio_dev_oe = drv_reg && !cfg_fw && !cs_n;
	assign link.serial_data_out_oe = drv_reg && cfg_fw && !cs_n;
endmodule

// >>> srcp_checker.sv
// Purpose: link-level checks between host and device ends
// Assumes: shift clock is made from clk_sys, so clk_sys samples it
// Notes: sees only the interface wires
module srcp_checker (
	input wire logic clk_sys,
	input wire logic rstn,
	input wire logic shift_clk,
	input wire logic chip_select_n,
	input wire logic sdio_host_oe,
	input wire logic sdio_dev_o,
	input wire logic sdio_dev_oe,
	input wire logic serial_data_out,
	input wire logic serial_data_out_oe
);
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!rstn);
	logic sck_q;
	logic [7:0] rise_cnt;
	always_ff @(posedge clk_sys)
	begin
		sck_q <= shift_clk;
	end
	// rises since select fell; cleared by select high, not by the frame end
	always_ff @(posedge clk_sys)
	begin
		if (!rstn || chip_select_n)
			rise_cnt <= 8'h00;
		else if (shift_clk && !sck_q)
			rise_cnt <= rise_cnt + 8'h01;
	end
	a_sdio_idle: assert property (
		chip_select_n |-> !sdio_dev_oe)
		else $error("data pin driven while deselected");
	a_sdo_idle: assert property (
		chip_select_n |-> !serial_data_out_oe)
		else $error("output pin driven while deselected");
	a_no_contention: assert property (
		!(sdio_dev_oe && sdio_host_oe))
		else $error("both ends drive the data pin");
	a_four_wire_pin: assert property (
		serial_data_out_oe |-> !sdio_dev_oe)
		else $error("four-wire read also drives data pin");
	a_instr_first: assert property (
		(sdio_dev_oe || serial_data_out_oe) |-> rise_cnt >= 8'h10)
		else $error("device drove before sixteen rises");
	a_sdio_launch: assert property (
		(sdio_dev_oe && $past(sdio_dev_oe) && $changed(sdio_dev_o))
		|-> $fell(shift_clk))
		else $error("data pin changed away from a falling edge");
	a_sdo_launch: assert property (
		(serial_data_out_oe && $past(serial_data_out_oe)
		&& $changed(serial_data_out)) |-> $fell(shift_clk))
		else $error("output pin changed away from a falling edge");
	a_whole_bytes: assert property (
		$rose(chip_select_n)
		|-> rise_cnt >= 8'h10 && rise_cnt[2:0] == 3'h0)
		else $error("frame ended off a byte boundary");
endmodule

// >>> tb.sv
// Purpose: bench joining host and device ends of the control port
// Assumes: host derives the shift clock from clk_sys
// Notes: host cannot break frames, so no faulty second link is built
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	import srcp_pkg::*;
	logic clk_sys = 1'b0;
	logic rstn = 1'b0;
	logic cmd_valid = 1'b0;
	logic cmd_read = 1'b0;
	logic cmd_lsb = 1'b0;
	logic cmd_fw = 1'b0;
	logic io_upd = 1'b0;
	logic strap = 1'b1;
	logic [14:0] cmd_addr = 15'h0000;
	logic [7:0] cmd_len = 8'h00;
	srcp_byte_t wr_data = 8'h00;
	logic cmd_ready, wr_ready, rd_valid, busy, spi_enabled;
	srcp_byte_t rd_data;
	srcp_regs_t active_regs;
	srcp_byte_t wq[$];
	srcp_byte_t rq[$];
	int error_cnt = 0;
	int num_checks = 0;
	srcp_if link();
	always #5 clk_sys = ~clk_sys;
	srcp_host i_srcp_host (.link(link), .clk_sys(clk_sys), .rstn(rstn),
		.cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_read(cmd_read),
		.cmd_addr(cmd_addr), .cmd_len(cmd_len), .cmd_lsb(cmd_lsb),
		.cmd_four_wire(cmd_fw), .wr_valid(1'b1), .wr_ready(wr_ready),
		.wr_data(wr_data), .rd_valid(rd_valid), .rd_data(rd_data),
		.busy(busy));
	srcp_device i_srcp_device (.link(link), .clk_sys(clk_sys), .rstn(rstn),
		.protocol_select_strap(strap), .io_update_pin(io_upd),
		.spi_enabled(spi_enabled), .active_regs(active_regs));
	srcp_checker i_srcp_checker (.clk_sys(clk_sys), .rstn(rstn),
		.shift_clk(link.shift_clk), .chip_select_n(link.chip_select_n),
		.sdio_host_oe(link.sdio_host_oe), .sdio_dev_o(link.sdio_dev_o),
		.sdio_dev_oe(link.sdio_dev_oe),
		.serial_data_out(link.serial_data_out),
		.serial_data_out_oe(link.serial_data_out_oe));
	// wr_valid stays high, so the host never stalls for data
	always @(posedge clk_sys)
	begin
		if (rd_valid === 1'b1)
			rq.push_back(rd_data);
		if (wr_ready === 1'b1 && wq.size() > 0)
		begin
			void'(wq.pop_front());
			wr_data <= (wq.size() > 0) ? wq[0] : 8'h00;
		end
	end
	task automatic give_verdict;
		$display("checks %0d, mismatches %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task automatic check(string what, srcp_byte_t exp, srcp_byte_t got);
		num_checks++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("unexpected %s: expected %h, seen %h", what, exp, got);
		end
	endtask
	task automatic frame(logic rd, logic [14:0] a, int n);
		int k;
		@(negedge clk_sys);
		cmd_read = rd;
		cmd_addr = a;
		cmd_len = 8'(n);
		cmd_valid = 1'b1;
		k = 0;
		do
		begin
			@(posedge clk_sys);
			k++;
		end
		while (cmd_ready !== 1'b1 && k < 50);
		if (cmd_ready !== 1'b1)
		begin
			error_cnt++;
			$display("unexpected cmd_ready: expected 1, seen %b", cmd_ready);
			give_verdict();
		end
		@(negedge clk_sys);
		cmd_valid = 1'b0;
		for (k = 0; k < 2000 && busy !== 1'b0; k++)
			@(negedge clk_sys);
		if (k >= 2000)
		begin
			error_cnt++;
			$display("unexpected frame end: expected idle, seen busy");
			give_verdict();
		end
	endtask
	task automatic wr(logic [14:0] a, srcp_byte_t d[$]);
		wq = d;
		wr_data = d[0];
		frame(1'b0, a, d.size());
	endtask
	task automatic rd_chk(string what, logic [14:0] a, srcp_byte_t e[$]);
		rq = {};
		frame(1'b1, a, e.size());
		check("byte_count", 8'(e.size()), 8'(rq.size()));
		foreach (e[i])
			check(what, e[i], (rq.size() > i) ? rq[i] : 8'hXX);
	endtask
	task automatic t_reset;
		check("spi_enabled", 8'h01, {7'h00, spi_enabled});
		check("active_reg2", 8'h00, active_regs[2]);
		rd_chk("config", 15'h0001, '{8'h00, 8'h00});
		$display("test reset done");
	endtask
	task automatic t_buffered;
		wr(15'h0004, '{8'h11, 8'h22, 8'h33});
		check("active_reg4", 8'h00, active_regs[4]);
		rd_chk("active", 15'h0004, '{8'h00, 8'h00, 8'h00});
		wr(15'h0001, '{8'h20});
		rd_chk("buffer", 15'h0004, '{8'h11, 8'h22, 8'h33});
		rd_chk("unmapped", 15'h0011, '{8'h00, 8'h00, 8'h00});
		wr(15'h000F, '{8'h01});
		repeat (10) @(negedge clk_sys);
		check("active_reg4", 8'h11, active_regs[4]);
		check("active_reg3", 8'h22, active_regs[3]);
		check("active_reg2", 8'h33, active_regs[2]);
		check("update_bit", 8'h00, {7'h00, active_regs[15][0]});
		$display("test buffered done");
	endtask
	task automatic t_pin_update;
		wr(15'h0009, '{8'hA5});
		check("pin_before", 8'h00, active_regs[9]);
		@(negedge clk_sys);
		io_upd = 1'b1;
		repeat (6) @(negedge clk_sys);
		io_upd = 1'b0;
		check("pin_after", 8'hA5, active_regs[9]);
		$display("test pin update done");
	endtask
	task automatic t_order;
		wr(15'h0000, '{8'h20});
		wr(15'h0005, '{8'h5A, 8'hC3});
		wr(15'h0000, '{8'h70});
		// the new order only holds from the following frame
		cmd_lsb = 1'b1;
		cmd_fw = 1'b1;
		rd_chk("lsb_four", 15'h0005, '{8'h5A, 8'hC3});
		wr(15'h0007, '{8'h96, 8'h0F});
		wr(15'h0000, '{8'h00});
		cmd_lsb = 1'b0;
		cmd_fw = 1'b0;
		rd_chk("msb_down", 15'h0008, '{8'h0F, 8'h96, 8'hC3});
		// unmapped and trigger slots padded with zeros, no update fired
		wr(15'h0010, '{8'h00, 8'h00, 8'hE7});
		rd_chk("padded", 15'h0010, '{8'h00, 8'h00, 8'hE7});
		$display("test order done");
	endtask
	task automatic t_strap;
		@(negedge clk_sys);
		rstn = 1'b0;
		strap = 1'b0;
		repeat (5) @(negedge clk_sys);
		rstn = 1'b1;
		repeat (6) @(negedge clk_sys);
		check("spi_off", 8'h00, {7'h00, spi_enabled});
		wr(15'h0004, '{8'h3C});
		// a silent device leaves the data pin at its idle high level
		rd_chk("ignored", 15'h0004, '{8'hFF});
		strap = 1'b1;
		repeat (6) @(negedge clk_sys);
		check("spi_held", 8'h00, {7'h00, spi_enabled});
		rstn = 1'b0;
		repeat (5) @(negedge clk_sys);
		rstn = 1'b1;
		repeat (6) @(negedge clk_sys);
		check("spi_back", 8'h01, {7'h00, spi_enabled});
		rd_chk("cleared", 15'h0004, '{8'h00});
		$display("test strap done");
	endtask
	initial
	begin
		repeat (5) @(negedge clk_sys);
		rstn = 1'b1;
		repeat (6) @(negedge clk_sys);
		t_reset();
		t_buffered();
		t_pin_update();
		t_order();
		t_strap();
		give_verdict();
	end
endmodule
